// ==== vsd_detector.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/100ps

module vsd_detector
  import vsd_pkg::*;
#(
  parameter int WORD_W = VSD_WORD_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WORD_W-1:0] video_word,
  input wire logic ext_h,
  input wire logic ext_v,
  input wire logic ext_f,
  input wire logic timing_source_select,
  input wire logic processing_bypass_n,
  input wire logic pll_locked,
  input wire vsd_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  output logic [4:0] standard_code,
  output logic interlace_flag,
  output logic flywheel_lock_flag
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (WORD_W != VSD_WORD_W) begin : g_bad_width
    $error("vsd_detector: only 10-bit video words are supported");
  end

  // ************************************************************
  // Classification
  // ************************************************************
  function automatic logic [4:0] vsd_classify(
    input logic [12:0] tw,
    input logic [12:0] aw,
    input logic [10:0] tl,
    input logic [10:0] al,
    input logic il
  );
    logic [4:0] c;
    c = (tl > VSD_SD_MAX_LINES) ? VSD_STD_UNK_HD : VSD_STD_UNK_SD;
    if (!il) begin
      // Progressive 720 line family, plain then EM
      if (tw == VSD_TS_1650 && aw == VSD_AW_1280) c = VSD_STD_720_60;
      else if (tw == VSD_TS_1650 && aw == VSD_AW_1440) c = 5'h01;
      else if (tw == VSD_TS_3300 && aw == VSD_AW_1280) c = 5'h02;
      else if (tw == VSD_TS_3300 && aw == VSD_AW_2880) c = 5'h03;
      else if (tw == VSD_TS_1980 && aw == VSD_AW_1280) c = 5'h04;
      else if (tw == VSD_TS_1980 && aw == VSD_AW_1728) c = 5'h05;
      else if (tw == VSD_TS_3960 && aw == VSD_AW_1280) c = 5'h06;
      else if (tw == VSD_TS_3960 && aw == VSD_AW_3456) c = 5'h07;
      else if (tw == VSD_TS_4125 && aw == VSD_AW_1280) c = 5'h08;
      else if (tw == VSD_TS_4125 && aw == VSD_AW_3600) c = 5'h09;
      // Progressive 1080 line family
      else if (tw == VSD_TS_2200 && aw == VSD_AW_1920)
        c = VSD_STD_1080P_30;
      else if (tw == VSD_TS_2640 && aw == VSD_AW_1920)
        c = VSD_STD_1080P_25;
      else if (tw == VSD_TS_2640 && aw == VSD_AW_2304)
        c = VSD_STD_1080P_25E;
      else if (tw == VSD_TS_2750 && aw == VSD_AW_1920)
        c = VSD_STD_1080P_24;
      else if (tw == VSD_TS_2750 && aw == VSD_AW_2400)
        c = VSD_STD_1080P_24E;
    end else begin
      // Interlaced and segmented frame family
      if (tw == VSD_TS_2200 && aw == VSD_AW_1920) begin
        if (al == VSD_AL_540) c = VSD_STD_1080I_60;
        else c = VSD_STD_1035I_60;
      end
      else if (tw == VSD_TS_2640 && aw == VSD_AW_1920)
        c = VSD_STD_1080I_50;
      else if (tw == VSD_TS_2640 && aw == VSD_AW_2304)
        c = VSD_STD_1080F_25E;
      else if (tw == VSD_TS_2750 && aw == VSD_AW_1920)
        c = VSD_STD_1080F_24;
      else if (tw == VSD_TS_2750 && aw == VSD_AW_2400)
        c = VSD_STD_1080F_24E;
      else if (tw == VSD_TS_2376 && aw == VSD_AW_1920)
        c = VSD_STD_1250I_50;
      else if (tw == VSD_TS_1716) begin
        // 525 line: active lines split 487 from 507
        if (al < VSD_AL_250) begin
          c = (aw == VSD_AW_1440) ? VSD_STD_525_487
                                  : VSD_STD_525_487G;
        end else begin
          c = (aw == VSD_AW_1440) ? VSD_STD_525_507
                                  : VSD_STD_525_507G;
        end
      end
      else if (tw == VSD_TS_1728) begin
        c = (aw == VSD_AW_1440 && al == VSD_AL_288) ? VSD_STD_625_576
                                                    : VSD_STD_625_GEN;
      end
    end
    return c;
  endfunction : vsd_classify

  function automatic logic [12:0] vsd_inc13(input logic [12:0] x);
    return (x == 13'h1FFF) ? x : x + 13'h0001;
  endfunction : vsd_inc13

  function automatic logic [10:0] vsd_inc11(input logic [10:0] x);
    return (x == 11'h7FF) ? x : x + 11'h001;
  endfunction : vsd_inc11

  // ************************************************************
  // State
  // ************************************************************
  vsd_state_t state_reg;
  vsd_state_t state_next;

  logic trs_found;
  logic force_zero;
  logic relearn;
  logic line_start;
  logic frame_start;
  logic field_end;
  logic mismatch;
  vsd_timing_t sel;

  always_comb begin
    state_next = state_reg;
    // Embedded timing word search, 8-bit or 10-bit words
    trs_found = (state_reg.w3[9:2] == VSD_TRS_ONES[9:2])
      && (state_reg.w2[9:2] == 8'h00)
      && (state_reg.w1[9:2] == 8'h00);
    force_zero = !processing_bypass_n || !pll_locked;
    relearn = bus_req.wr && (bus_req.addr == VSD_OFS_CONTROL)
      && bus_req.wdata[VSD_CTL_RELEARN];
    state_next.w3 = state_reg.w2;
    state_next.w2 = state_reg.w1;
    state_next.w1 = video_word;
    if (trs_found) begin
      state_next.trs.h = video_word[VSD_XYZ_H];
      state_next.trs.v = video_word[VSD_XYZ_V];
      state_next.trs.f = video_word[VSD_XYZ_F];
    end

    // Timing source select
    if (timing_source_select) begin
      sel = state_next.trs;
    end else begin
      sel.h = ext_h;
      sel.v = ext_v;
      sel.f = ext_f;
    end
    state_next.cur = sel;

    // A line starts where horizontal blanking begins
    line_start = sel.h && !state_reg.cur.h;
    frame_start = line_start && sel.v && !sel.f
      && (!state_reg.line_v || state_reg.line_f);
    field_end = line_start && sel.v && !state_reg.line_v;
    mismatch = 1'b0;

    // Word counting
    if (line_start) begin
      state_next.word_cnt = 13'h0001;
      state_next.act_cnt = 13'h0000;
    end else begin
      state_next.word_cnt = vsd_inc13(state_reg.word_cnt);
      if (!sel.h && !sel.v) begin
        state_next.act_cnt = vsd_inc13(state_reg.act_cnt);
      end else if (!sel.h) begin
        state_next.act_cnt = vsd_inc13(state_reg.act_cnt);
      end
    end

    // Line and field counting
    if (line_start) begin
      state_next.line_v = sel.v;
      state_next.line_f = sel.f;
      if (sel.f) begin
        state_next.int_seen = 1'b1;
      end
      if (field_end) begin
        state_next.field_act = state_reg.act_lines;
        state_next.act_lines = 11'h000;
      end else if (!sel.v) begin
        state_next.act_lines = vsd_inc11(state_reg.act_lines);
      end
      if (frame_start) begin
        state_next.line_no = 11'h001;
        state_next.frame_lines = state_reg.line_no;
        state_next.int_frame = state_reg.int_seen || sel.f;
        state_next.int_seen = 1'b0;
      end else begin
        state_next.line_no = vsd_inc11(state_reg.line_no);
      end
      if (state_reg.lock_state == VSD_LS_LOCKED
          && state_reg.word_cnt != state_reg.ref_words) begin
        mismatch = 1'b1;
      end
    end

    // Flywheel lock sequence
    case (state_reg.lock_state)
      VSD_LS_SEARCH: begin
        if (frame_start) begin
          state_next.lock_state = VSD_LS_LEARN;
        end
      end
      VSD_LS_LEARN: begin
        if (line_start) begin
          state_next.ref_words = state_reg.word_cnt;
        end
        if (frame_start) begin
          // Whole frame seen between two frame starts
          state_next.ref_lines = state_reg.line_no;
          state_next.lock_state = VSD_LS_LOCKED;
        end
      end
      VSD_LS_LOCKED: begin
        if (mismatch
            || (frame_start && state_reg.line_no != state_reg.ref_lines))
        begin
          state_next.lock_state = VSD_LS_SEARCH;
        end
      end
      default: begin
        state_next.lock_state = VSD_LS_SEARCH;
      end
    endcase
    if (relearn) begin
      state_next.lock_state = VSD_LS_SEARCH;
    end

    // Once-per-frame publication at the end of line 12
    if (line_start && state_reg.line_no == VSD_UPDATE_LINE
        && state_reg.lock_state != VSD_LS_SEARCH) begin
      state_next.act_words_out = state_reg.act_cnt;
      state_next.tot_words_out = state_reg.word_cnt;
      state_next.tot_lines_out = state_reg.frame_lines;
      state_next.act_lines_out = state_reg.field_act;
      state_next.std_code = vsd_classify(state_reg.word_cnt,
        state_reg.act_cnt, state_reg.frame_lines, state_reg.field_act,
        state_reg.int_frame);
      state_next.interlace = state_reg.int_frame;
    end
    if (force_zero) begin
      state_next.std_code = 5'h00;
      state_next.interlace = 1'b0;
    end

    // Register read port, data one cycle after the strobe
    state_next.rdata = VSD_RESET_VAL;
    if (bus_req.rd) begin
      if (bus_req.addr == VSD_OFS_STATUS) begin
        state_next.rdata[VSD_STD_LSB +: 5] = state_reg.std_code;
        state_next.rdata[VSD_INT_BIT] = state_reg.interlace;
        state_next.rdata[VSD_LOCK_BIT] =
          (state_reg.lock_state == VSD_LS_LOCKED);
      end else if (bus_req.addr == VSD_OFS_ACT_WORDS) begin
        state_next.rdata[VSD_WCNT_FIELD_W-1:0] =
          state_reg.act_words_out[VSD_WCNT_FIELD_W-1:0];
      end else if (bus_req.addr == VSD_OFS_TOT_WORDS) begin
        state_next.rdata[VSD_WCNT_FIELD_W-1:0] =
          state_reg.tot_words_out[VSD_WCNT_FIELD_W-1:0];
      end else if (bus_req.addr == VSD_OFS_TOT_LINES) begin
        state_next.rdata[VSD_LCNT_FIELD_W-1:0] =
          state_reg.tot_lines_out;
      end else if (bus_req.addr == VSD_OFS_ACT_LINES) begin
        state_next.rdata[VSD_LCNT_FIELD_W-1:0] =
          state_reg.act_lines_out;
      end else begin
        state_next.rdata = VSD_RESET_VAL;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Lock state only moves on clock edges or async reset, so it holds if mclk stops outside reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.lock_state <= VSD_LS_SEARCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus_rdata = state_reg.rdata;
  assign standard_code = state_reg.std_code;
  assign interlace_flag = state_reg.interlace;
  assign flywheel_lock_flag = (state_reg.lock_state == VSD_LS_LOCKED);

endmodule : vsd_detector

// ==== vsd_pkg.sv ====
package vsd_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int VSD_ADDR_W = 12;
  localparam int VSD_DATA_W = 16;
  localparam int VSD_WORD_W = 10;
  localparam int VSD_PIX_W = 13;
  localparam int VSD_LINE_W = 11;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [11:0] VSD_OFS_STATUS = 12'h004;
  localparam logic [11:0] VSD_OFS_ACT_WORDS = 12'h00E;
  localparam logic [11:0] VSD_OFS_TOT_WORDS = 12'h00F;
  localparam logic [11:0] VSD_OFS_TOT_LINES = 12'h010;
  localparam logic [11:0] VSD_OFS_ACT_LINES = 12'h011;
  localparam logic [11:0] VSD_OFS_CONTROL = 12'h01F;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int VSD_STD_LSB = 10;
  localparam int VSD_INT_BIT = 9;
  localparam int VSD_LOCK_BIT = 8;
  localparam int VSD_CTL_RELEARN = 0;
  localparam int VSD_WCNT_FIELD_W = 12;
  localparam int VSD_LCNT_FIELD_W = 11;
  localparam logic [15:0] VSD_RESET_VAL = 16'h0000;
  localparam logic [10:0] VSD_UPDATE_LINE = 11'h00C;
  localparam logic [9:0] VSD_TRS_ONES = 10'h3FF;

  // ************************************************************
  // Embedded timing word flag positions
  // ************************************************************
  localparam int VSD_XYZ_F = 8;
  localparam int VSD_XYZ_V = 7;
  localparam int VSD_XYZ_H = 6;

  // ************************************************************
  // Standard codes
  // ************************************************************
  localparam logic [4:0] VSD_STD_720_60 = 5'h00;
  localparam logic [4:0] VSD_STD_1080I_60 = 5'h0A;
  localparam logic [4:0] VSD_STD_1080P_30 = 5'h0B;
  localparam logic [4:0] VSD_STD_1080I_50 = 5'h0C;
  localparam logic [4:0] VSD_STD_1080P_25 = 5'h0D;
  localparam logic [4:0] VSD_STD_1080P_25E = 5'h0E;
  localparam logic [4:0] VSD_STD_1080F_25E = 5'h0F;
  localparam logic [4:0] VSD_STD_1080P_24 = 5'h10;
  localparam logic [4:0] VSD_STD_1080F_24 = 5'h11;
  localparam logic [4:0] VSD_STD_1080P_24E = 5'h12;
  localparam logic [4:0] VSD_STD_1080F_24E = 5'h13;
  localparam logic [4:0] VSD_STD_1250I_50 = 5'h14;
  localparam logic [4:0] VSD_STD_1035I_60 = 5'h15;
  localparam logic [4:0] VSD_STD_525_487 = 5'h16;
  localparam logic [4:0] VSD_STD_525_507 = 5'h17;
  localparam logic [4:0] VSD_STD_625_576 = 5'h18;
  localparam logic [4:0] VSD_STD_525_487G = 5'h19;
  localparam logic [4:0] VSD_STD_625_GEN = 5'h1A;
  localparam logic [4:0] VSD_STD_525_507G = 5'h1B;
  localparam logic [4:0] VSD_STD_UNK_HD = 5'h1D;
  localparam logic [4:0] VSD_STD_UNK_SD = 5'h1E;

  // ************************************************************
  // Raster figures used for matching
  // ************************************************************
  localparam logic [12:0] VSD_TS_1650 = 13'h0672;
  localparam logic [12:0] VSD_TS_3300 = 13'h0CE4;
  localparam logic [12:0] VSD_TS_1980 = 13'h07BC;
  localparam logic [12:0] VSD_TS_3960 = 13'h0F78;
  localparam logic [12:0] VSD_TS_4125 = 13'h101D;
  localparam logic [12:0] VSD_TS_2200 = 13'h0898;
  localparam logic [12:0] VSD_TS_2640 = 13'h0A50;
  localparam logic [12:0] VSD_TS_2750 = 13'h0ABE;
  localparam logic [12:0] VSD_TS_2376 = 13'h0948;
  localparam logic [12:0] VSD_TS_1716 = 13'h06B4;
  localparam logic [12:0] VSD_TS_1728 = 13'h06C0;
  localparam logic [12:0] VSD_AW_1280 = 13'h0500;
  localparam logic [12:0] VSD_AW_1440 = 13'h05A0;
  localparam logic [12:0] VSD_AW_1920 = 13'h0780;
  localparam logic [12:0] VSD_AW_2304 = 13'h0900;
  localparam logic [12:0] VSD_AW_2400 = 13'h0960;
  localparam logic [12:0] VSD_AW_1728 = 13'h06C0;
  localparam logic [12:0] VSD_AW_2880 = 13'h0B40;
  localparam logic [12:0] VSD_AW_3456 = 13'h0D80;
  localparam logic [12:0] VSD_AW_3600 = 13'h0E10;
  localparam logic [10:0] VSD_AL_540 = 11'h21C;
  localparam logic [10:0] VSD_AL_250 = 11'h0FA;
  localparam logic [10:0] VSD_AL_288 = 11'h120;
  localparam logic [10:0] VSD_SD_MAX_LINES = 11'h271;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    VSD_LS_SEARCH,
    VSD_LS_LEARN,
    VSD_LS_LOCKED
  } vsd_lock_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } vsd_bus_req_t;

  typedef struct packed {
    logic h;
    logic v;
    logic f;
  } vsd_timing_t;

  typedef struct packed {
    logic [9:0] w1;
    logic [9:0] w2;
    logic [9:0] w3;
    vsd_timing_t trs;
    vsd_timing_t cur;
    logic line_v;
    logic line_f;
    logic [12:0] word_cnt;
    logic [12:0] act_cnt;
    logic [12:0] ref_words;
    logic [10:0] line_no;
    logic [10:0] act_lines;
    logic [10:0] field_act;
    logic [10:0] frame_lines;
    logic [10:0] ref_lines;
    logic int_seen;
    logic int_frame;
    vsd_lock_state_t lock_state;
    logic [12:0] act_words_out;
    logic [12:0] tot_words_out;
    logic [10:0] tot_lines_out;
    logic [10:0] act_lines_out;
    logic [4:0] std_code;
    logic interlace;
    logic [15:0] rdata;
  } vsd_state_t;

endpackage : vsd_pkg

// ==== vsd_properties.sv ====
`timescale 1ns/100ps
module vsd_properties
  import vsd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic processing_bypass_n,
  input wire logic pll_locked,
  input wire vsd_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic [4:0] standard_code,
  input wire logic interlace_flag,
  input wire logic flywheel_lock_flag
);
  // ************************************************************
  // Decoded reads and relearn write
  // ************************************************************
  wire rd_st = bus_req.rd && bus_req.addr == VSD_OFS_STATUS;
  wire rd_words = bus_req.rd && (bus_req.addr == VSD_OFS_ACT_WORDS ||
                                 bus_req.addr == VSD_OFS_TOT_WORDS);
  wire rd_lines = bus_req.rd && (bus_req.addr == VSD_OFS_TOT_LINES ||
                                 bus_req.addr == VSD_OFS_ACT_LINES);
  wire relearn = bus_req.wr && bus_req.addr == VSD_OFS_CONTROL &&
                 bus_req.wdata[VSD_CTL_RELEARN];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ************************************************************
  // Properties
  // ************************************************************
  a_rdata_idle: assert property (
    !bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not idle outside a read");
  a_status_map: assert property (
    rd_st |=> bus_rdata == {1'b0, $past(standard_code),
      $past(interlace_flag), $past(flywheel_lock_flag), 8'h00})
    else $error("status word does not match flags");
  a_word_width: assert property (
    rd_words |=> bus_rdata[15:12] == 4'h0)
    else $error("word count upper bits set");
  a_line_width: assert property (
    rd_lines |=> bus_rdata[15:11] == 5'h00)
    else $error("line count upper bits set");
  a_force_zero: assert property (
    !processing_bypass_n || !pll_locked |=>
      standard_code == 5'h00 && !interlace_flag)
    else $error("code not forced to zero");
  a_code_legal: assert property (
    standard_code != 5'h1C && standard_code != 5'h1F)
    else $error("reserved standard code");
  a_reset_clear: assert property (
    $fell(reset) |-> standard_code == 5'h00 && !interlace_flag &&
      !flywheel_lock_flag)
    else $error("status not clear after reset");
  a_lock_delay: assert property (
    $fell(reset) |-> !flywheel_lock_flag [*8])
    else $error("lock too early after reset");
  a_relearn_drop: assert property (
    relearn |=> !flywheel_lock_flag)
    else $error("lock kept after relearn");

  cover property ($rose(flywheel_lock_flag));
  cover property (interlace_flag && standard_code == VSD_STD_UNK_SD);
  cover property (!processing_bypass_n ##1 standard_code == 5'h00);
endmodule : vsd_properties

// ==== vsd_source.sv ====
`timescale 1ns/100ps
module vsd_source
  import vsd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic interlaced,
  input wire logic [7:0] tw,
  output logic [9:0] video_word,
  output logic ext_h,
  output logic ext_v,
  output logic ext_f
);
  // ************************************************************
  // Raster counters, 20 lines, 8 blanking words
  // ************************************************************
  logic [7:0] wc;
  logic [4:0] lc;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wc <= 8'h00;
      lc <= 5'h13;
    end else if (wc >= tw - 8'h01) begin
      wc <= 8'h00;
      lc <= (lc == 5'h13) ? 5'h00 : lc + 5'h01;
    end else begin
      wc <= wc + 8'h01;
    end
  end

  // ************************************************************
  // External levels and embedded words
  // ************************************************************
  always_comb begin
    ext_f = interlaced && lc >= 5'h0A;
    ext_v = interlaced ? (lc == 5'h00 || lc == 5'h01 || lc == 5'h0A ||
                          lc == 5'h0B) : (lc < 5'h04);
    ext_h = wc < 8'h08;
    case (wc)
      8'h00, 8'h04: video_word = VSD_TRS_ONES;
      8'h01, 8'h02, 8'h05, 8'h06: video_word = 10'h000;
      8'h03: video_word = {1'b1, ext_f, ext_v, 1'b1, 6'h00};
      8'h07: video_word = {1'b1, ext_f, ext_v, 1'b0, 6'h00};
      default: video_word = 10'h200;
    endcase
  end
endmodule : vsd_source

// ==== vsd_detector_test.sv ====
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  $display("[ERR] %s exp %h got %h", nm, exp, got); fail_count++; end end
module vsd_detector_test;
  import vsd_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic timing_source_select = 1'b0;
  logic processing_bypass_n = 1'b1;
  logic pll_locked = 1'b1;
  logic interlaced = 1'b0;
  logic [7:0] tw = 8'h28;
  vsd_bus_req_t bus_req = '0;
  logic [9:0] video_word;
  logic ext_h;
  logic ext_v;
  logic ext_f;
  logic [15:0] bus_rdata;
  logic [4:0] standard_code;
  logic interlace_flag;
  logic flywheel_lock_flag;
  int fail_count = 0;
  int cmp_count = 0;

  initial begin
    forever #50 mclk = ~mclk;
  end

  vsd_source vsd_source_inst (.mclk(mclk), .reset(reset),
    .interlaced(interlaced), .tw(tw), .video_word(video_word),
    .ext_h(ext_h), .ext_v(ext_v), .ext_f(ext_f));
  vsd_detector vsd_detector_inst (.mclk(mclk), .reset(reset),
    .video_word(video_word), .ext_h(ext_h), .ext_v(ext_v), .ext_f(ext_f),
    .timing_source_select(timing_source_select),
    .processing_bypass_n(processing_bypass_n), .pll_locked(pll_locked),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .standard_code(standard_code), .interlace_flag(interlace_flag),
    .flywheel_lock_flag(flywheel_lock_flag));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic final_report;
    $display("COUNTS compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #10;
    `CHK(nm, e, bus_rdata)
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic wait_lock;
    int n = 0;
    while (flywheel_lock_flag !== 1'b1) begin
      @(posedge mclk);
      #10;
      n++;
      if (n > 4000) begin
        `CHK("lock wait", 1'b1, 1'b0)
        final_report();
      end
    end
    repeat (13 * tw) @(posedge mclk);
  endtask : wait_lock

  task automatic wait_code(input logic [4:0] e);
    int n = 0;
    while (standard_code !== e) begin
      @(posedge mclk);
      #10;
      n++;
      if (n > 1000) begin
        `CHK("code wait", e, standard_code)
        final_report();
      end
    end
  endtask : wait_code

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    logic [11:0] ofs [5] = '{VSD_OFS_STATUS, VSD_OFS_ACT_WORDS,
      VSD_OFS_TOT_WORDS, VSD_OFS_TOT_LINES, VSD_OFS_ACT_LINES};
    `CHK("lock after reset", 1'b0, flywheel_lock_flag)
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], 16'h0000, "reset value");
    end
    rd(12'h005, 16'h0000, "unmapped");
    wr(VSD_OFS_STATUS, 16'hFFFF);
    rd(VSD_OFS_STATUS, 16'h0000, "status read only");
    $display("test reset done");
  endtask : t_reset

  task automatic t_prog;
    wait_lock();
    rd(VSD_OFS_STATUS, 16'h7900, "prog status");
    rd(VSD_OFS_ACT_WORDS, 16'h0020, "active words");
    rd(VSD_OFS_TOT_WORDS, 16'h0028, "total words");
    rd(VSD_OFS_TOT_LINES, 16'h0014, "total lines");
    rd(VSD_OFS_ACT_LINES, 16'h0010, "active lines");
    $display("test progressive done");
  endtask : t_prog

  task automatic t_inter;
    @(posedge mclk);
    interlaced <= 1'b1;
    wr(VSD_OFS_CONTROL, 16'h0001);
    #10;
    `CHK("lock after relearn", 1'b0, flywheel_lock_flag)
    wait_lock();
    rd(VSD_OFS_STATUS, 16'h7B00, "interlaced status");
    rd(VSD_OFS_TOT_LINES, 16'h0014, "total lines");
    rd(VSD_OFS_ACT_LINES, 16'h0008, "field lines");
    $display("test interlaced done");
  endtask : t_inter

  task automatic t_force;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      if (i == 0) processing_bypass_n <= 1'b0;
      else pll_locked <= 1'b0;
      repeat (2) @(posedge mclk);
      #10;
      `CHK("forced code", 5'h00, standard_code)
      `CHK("forced interlace", 1'b0, interlace_flag)
      `CHK("lock kept", 1'b1, flywheel_lock_flag)
      @(posedge mclk);
      processing_bypass_n <= 1'b1;
      pll_locked <= 1'b1;
      wait_code(VSD_STD_UNK_SD);
    end
    $display("test force done");
  endtask : t_force

  task automatic t_embed;
    @(posedge mclk);
    timing_source_select <= 1'b1;
    tw <= 8'h30;
    wr(VSD_OFS_CONTROL, 16'h0001);
    rd(VSD_OFS_TOT_WORDS, 16'h0028, "held words");
    wait_lock();
    rd(VSD_OFS_STATUS, 16'h7B00, "embedded status");
    rd(VSD_OFS_ACT_WORDS, 16'h002C, "embedded active");
    rd(VSD_OFS_TOT_WORDS, 16'h0030, "embedded words");
    rd(VSD_OFS_TOT_LINES, 16'h0014, "embedded lines");
    $display("test embedded done");
  endtask : t_embed

  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_prog();
    t_inter();
    t_force();
    t_embed();
    final_report();
  end
endmodule : vsd_detector_test

bind vsd_detector vsd_properties vsd_properties_inst (.mclk(mclk),
  .reset(reset), .processing_bypass_n(processing_bypass_n),
  .pll_locked(pll_locked), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .standard_code(standard_code), .interlace_flag(interlace_flag),
  .flywheel_lock_flag(flywheel_lock_flag));
